// ==== sbr_pkg.sv ====
// Purpose: shared constants and state types for the byte reorder block
// Assumes: 32-bit words, word length code 0 means a full 32-bit word
// Notes:   gap length on the link is suspend setting plus GAP_MIN link cycles
package sbr_pkg;
    localparam int unsigned WORD_W      = 32;
    localparam int unsigned LEN_W       = 5;
    localparam int unsigned CNT_W       = 6;
    localparam int unsigned SYNC_STAGES = 2;
    // byte order select codes
    localparam logic [1:0] ORDER_PLAIN    = 2'h0;
    localparam logic [1:0] ORDER_SWAP_GAP = 2'h1;
    localparam logic [1:0] ORDER_SWAP     = 2'h2;
    localparam logic [1:0] ORDER_GAP      = 2'h3;
    // word length codes that allow reordering
    localparam logic [4:0] LEN_32 = 5'h00;
    localparam logic [4:0] LEN_16 = 5'h10;
    localparam logic [4:0] LEN_24 = 5'h18;
    localparam logic [5:0] FULL_BITS = 6'h20;
    // gap of 2 to 17 link cycles
    localparam logic [4:0] GAP_MIN = 5'h02;
    localparam logic [2:0] BYTE_LAST_BIT = 3'h7;
    // reset values
    localparam logic RESET_DONE = 1'b0;
    localparam logic RESET_TGL  = 1'b0;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_WAIT = 1'b1
    } sbr_ctrl_state_type;

    typedef enum logic [1:0] {
        LK_IDLE  = 2'b00,
        LK_SHIFT = 2'b01,
        LK_GAP   = 2'b10
    } sbr_link_state_type;
endpackage

// ==== sbr_sync.sv ====
// Purpose: two-stage synchroniser for levels and toggles
// Assumes: inputs are levels or toggles that hold for several target cycles
// Notes:   first stage is read only by the second stage
module sbr_sync #(
    parameter int unsigned WIDTH = 1
) (
    // clock
    input  wire logic             clock,
    // data
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] safe;
    } sbr_sync_st_type;

    sbr_sync_st_type q;
    sbr_sync_st_type d;

    if (WIDTH < 1) begin : g_chk
        $error("sbr_sync: WIDTH must be at least 1");
    end

    always_comb begin
        d      = q;
        d.meta = async_in;
        d.safe = q.meta;
    end

    // no reset: the chain settles within two edges anyway
    always_ff @(posedge clock) begin
        q <= d;
    end

    assign sync_out = q.safe;
endmodule // sbr_sync

// ==== sbr_link.sv ====
// Purpose: serial-clock side shifter with byte suspend gaps
// Assumes: word and settings stay stable while a request toggle is pending
// Notes:   request and acknowledge cross as toggles; reset is synchronised here
module sbr_link (
    // link clock
    input  wire logic        link_clk,
    input  wire logic        reset_n,
    // word from the system side
    input  wire logic [31:0] word,
    input  wire logic [5:0]  nbits,
    input  wire logic        gap_en,
    input  wire logic [4:0]  gap_len,
    input  wire logic        slave_mode,
    input  wire logic        req_tgl,
    input  wire logic        ss_n_i,
    // to the system side and the pins
    output logic             ack_tgl,
    output logic             serial_out,
    output logic             frame,
    output logic             clk_run
);
    typedef struct packed {
        sbr_pkg::sbr_link_state_type state;
        logic [31:0]                 shreg;
        logic [5:0]                  bitcnt;
        logic [4:0]                  gapcnt;
        logic                        req_seen;
        logic                        ack;
        logic                        frame;
    } sbr_link_st_type;

    sbr_link_st_type q;
    sbr_link_st_type d;
    logic [3:0]      sync_s;
    logic            rst_n_s;
    logic            req_s;
    logic            slave_s;
    logic            ss_n_s;

    sbr_sync #(.WIDTH(4)) u_sync (
        .clock    (link_clk),
        .async_in ({reset_n, req_tgl, slave_mode, ss_n_i}),
        .sync_out (sync_s)
    );
    assign {rst_n_s, req_s, slave_s, ss_n_s} = sync_s;

    always_comb begin
        d = q;
        case (q.state)
            sbr_pkg::LK_IDLE: begin
                // slave relies on peer holding select
                if (req_s != q.req_seen && (!slave_s || !ss_n_s)) begin
                    d.req_seen = req_s;
                    d.shreg    = word;
                    d.bitcnt   = '0;
                    d.frame    = 1'b1;
                    d.state    = sbr_pkg::LK_SHIFT;
                end
            end
            sbr_pkg::LK_SHIFT: begin
                d.shreg  = {q.shreg[30:0], 1'b0};
                d.bitcnt = q.bitcnt + 6'h01;
                if (q.bitcnt == nbits - 6'h01) begin
                    d.ack   = ~q.ack;
                    d.frame = 1'b0;
                    d.state = sbr_pkg::LK_IDLE;
                // gap after each byte but the last; peer keeps select
                end else if (gap_en && q.bitcnt[2:0] == sbr_pkg::BYTE_LAST_BIT) begin
                    d.gapcnt = gap_len - 5'h01;
                    d.state  = sbr_pkg::LK_GAP;
                end
            end
            sbr_pkg::LK_GAP: begin
                d.gapcnt = q.gapcnt - 5'h01;
                if (q.gapcnt == 5'h00) begin
                    d.state = sbr_pkg::LK_SHIFT;
                end
            end
            default: begin
                d.state = sbr_pkg::LK_IDLE;
            end
        endcase
    end

    always_ff @(posedge link_clk) begin
        if (!rst_n_s) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign ack_tgl    = q.ack;
    assign serial_out = q.shreg[31];
    assign frame      = q.frame;
    assign clk_run    = (q.state == sbr_pkg::LK_SHIFT);

    // gap lasts two link cycles at least
    AST_GAP_MIN: assert property (@(posedge link_clk) disable iff (!rst_n_s)
        $rose(q.state == sbr_pkg::LK_GAP) |-> (q.state == sbr_pkg::LK_GAP)[*2])
        else $error("suspend gap shorter than two link cycles");
    AST_NO_GAP: assert property (@(posedge link_clk) disable iff (!rst_n_s)
        (q.state == sbr_pkg::LK_SHIFT && !gap_en) |=> q.state != sbr_pkg::LK_GAP)
        else $error("gap inserted while gaps disabled");
    AST_SLAVE_WAIT: assert property (@(posedge link_clk) disable iff (!rst_n_s)
        (q.state == sbr_pkg::LK_IDLE && slave_s && ss_n_s) |=> q.state == sbr_pkg::LK_IDLE)
        else $error("slave started without active select");
    COV_GAP: cover property (@(posedge link_clk) disable iff (!rst_n_s)
        q.state == sbr_pkg::LK_GAP ##1 q.state == sbr_pkg::LK_SHIFT);
endmodule // sbr_link

// ==== sbr_ctrl.sv ====
// Purpose: byte order, suspend gap, role and done/interrupt control
// Assumes: config ports are steady while busy; go is a one-cycle pulse
// Notes:   the serial side runs on link_clk; words cross by toggle handshake
//          while the word registers are held stable

// Functional notes
// - order select 00: no reordering and no suspend gaps.
// - order select 01: reorder plus 2 to 17 cycle gaps; 32-bit words.
// - order select 10: reorder bytes, no suspend gaps.
// - order select 11: original order with gaps; 32-bit words only.
// - reordering acts only for word lengths 16, 24 and 32.
// - transfer interrupt passes only while interrupt enable is one.
// - done flag set when transfer finishes, zero while in progress.
// - writing one clears the done flag; zero leaves it.
module sbr_ctrl (
    // system clock and reset
    input  wire logic        clock,
    input  wire logic        reset_n,
    // configuration
    input  wire logic        fifo_mode,
    input  wire logic [1:0]  byte_order_sel,
    input  wire logic [1:0]  burst_count,
    input  wire logic        slave_mode,
    input  wire logic        irq_enable,
    input  wire logic [4:0]  word_length,
    input  wire logic [3:0]  suspend_cycles,
    // transfer request and status
    input  wire logic        go,
    input  wire logic [31:0] tx_word,
    input  wire logic        done_clear,
    output logic             busy,
    output logic             transfer_done,
    output logic             irq,
    output logic             config_error,
    // link side
    input  wire logic        link_clk,
    input  wire logic        ss_n_i,
    output logic             ss_n_o,
    output logic             ss_n_oe,
    output logic             serial_clock_pin_o,
    output logic             serial_clock_pin_oe,
    output logic             serial_out_o,
    output logic             serial_out_oe
);
    typedef struct packed {
        sbr_pkg::sbr_ctrl_state_type state;
        logic [31:0]                 word;
        logic [5:0]                  nbits;
        logic                        gap_en;
        logic [4:0]                  gap_len;
        logic                        req_tgl;
        logic                        done;
        logic                        irq;
        logic                        cfg_err;
    } sbr_ctrl_st_type;

    sbr_ctrl_st_type q;
    sbr_ctrl_st_type d;
    logic            ack_tgl;
    logic            ack_s;
    logic            frame;
    logic            clk_run;
    logic            link_out;
    logic            reorder_on;
    logic            gap_wanted;
    logic [5:0]      nbits_now;
    logic [31:0]     ordered;
    logic [31:0]     aligned;

    // reverse bytes within the configured word
    function automatic logic [31:0] swap_bytes(input logic [31:0] w, input logic [4:0] len);
        case (len)
            sbr_pkg::LEN_16: swap_bytes = {16'h0000, w[7:0], w[15:8]};
            sbr_pkg::LEN_24: swap_bytes = {8'h00, w[7:0], w[15:8], w[23:16]};
            sbr_pkg::LEN_32: swap_bytes = {w[7:0], w[15:8], w[23:16], w[31:24]};
            default:         swap_bytes = w;
        endcase
    endfunction

    // only codes 01 and 10 reorder; 00 keeps order
    assign reorder_on = byte_order_sel[0] ^ byte_order_sel[1];
    // codes 01 and 11 insert gaps, only for 32-bit words
    assign gap_wanted = byte_order_sel[0] && (word_length == sbr_pkg::LEN_32);
    assign nbits_now  = (word_length == sbr_pkg::LEN_32) ? sbr_pkg::FULL_BITS
                                                         : {1'b0, word_length};
    assign ordered    = reorder_on ? swap_bytes(tx_word, word_length) : tx_word;
    // msb-first shifter wants the word left aligned
    assign aligned    = ordered << (sbr_pkg::FULL_BITS - nbits_now);

    sbr_sync #(.WIDTH(1)) u_ack_sync (
        .clock    (clock),
        .async_in (ack_tgl),
        .sync_out (ack_s)
    );

    always_comb begin
        d = q;
        // flag the forbidden fifo combinations; length mismatch too
        d.cfg_err = (fifo_mode && (byte_order_sel != sbr_pkg::ORDER_PLAIN
                                   || burst_count != 2'h0))
                    || (byte_order_sel[0] && word_length != sbr_pkg::LEN_32);
        if (done_clear) begin
            d.done = 1'b0;
        end
        case (q.state)
            sbr_pkg::ST_IDLE: begin
                if (go) begin
                    d.word    = aligned;
                    d.nbits   = nbits_now;
                    d.gap_en  = gap_wanted;
                    d.gap_len = {1'b0, suspend_cycles} + sbr_pkg::GAP_MIN;
                    d.req_tgl = ~q.req_tgl;
                    // flag low while the transfer runs
                    d.done    = 1'b0;
                    d.state   = sbr_pkg::ST_WAIT;
                end
            end
            sbr_pkg::ST_WAIT: begin
                // set on completion, wins over a clear
                if (ack_s == q.req_tgl) begin
                    d.done  = 1'b1;
                    d.state = sbr_pkg::ST_IDLE;
                end
            end
            default: begin
                d.state = sbr_pkg::ST_IDLE;
            end
        endcase
        // gate the request with the enable
        d.irq = d.done && irq_enable;
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            q         <= '0;
            q.done    <= sbr_pkg::RESET_DONE;
            q.req_tgl <= sbr_pkg::RESET_TGL;
        end else begin
            q <= d;
        end
    end

    sbr_link u_link (
        .link_clk   (link_clk),
        .reset_n    (reset_n),
        .word       (q.word),
        .nbits      (q.nbits),
        .gap_en     (q.gap_en),
        .gap_len    (q.gap_len),
        .slave_mode (slave_mode),
        .req_tgl    (q.req_tgl),
        .ss_n_i     (ss_n_i),
        .ack_tgl    (ack_tgl),
        .serial_out (link_out),
        .frame      (frame),
        .clk_run    (clk_run)
    );

    assign busy          = (q.state == sbr_pkg::ST_WAIT);
    assign transfer_done = q.done;
    assign irq           = q.irq;
    assign config_error  = q.cfg_err;

    // master drives clock and select, slave drives only serial_out_o
    assign serial_clock_pin_oe = !slave_mode;
    assign ss_n_oe             = !slave_mode;
    // clock pulses only in shift cycles; gaps hold it idle low
    // pulse on the low phase: enable moves on the rising edge, so no glitch
    assign serial_clock_pin_o  = !link_clk & clk_run;
    assign ss_n_o              = !frame;
    assign serial_out_o        = link_out;
    assign serial_out_oe       = frame;

    AST_PLAIN_ORDER: assert property (@(posedge clock) disable iff (!reset_n)
        (go && !busy && byte_order_sel == sbr_pkg::ORDER_PLAIN
         && word_length == sbr_pkg::LEN_32)
        |=> q.word == $past(tx_word) && !q.gap_en)
        else $error("plain order altered the word or enabled gaps");
    AST_SWAP_GAP: assert property (@(posedge clock) disable iff (!reset_n)
        (go && !busy && byte_order_sel == sbr_pkg::ORDER_SWAP_GAP
         && word_length == sbr_pkg::LEN_32)
        |=> q.gap_en && q.word == {$past(tx_word[7:0]), $past(tx_word[15:8]),
                                   $past(tx_word[23:16]), $past(tx_word[31:24])})
        else $error("order 01 did not swap with gaps");
    AST_SWAP_ONLY: assert property (@(posedge clock) disable iff (!reset_n)
        (go && !busy && byte_order_sel == sbr_pkg::ORDER_SWAP
         && word_length == sbr_pkg::LEN_16)
        |=> !q.gap_en && q.word[31:16] == {$past(tx_word[7:0]), $past(tx_word[15:8])})
        else $error("order 10 did not swap 16-bit word without gaps");
    AST_GAP_ONLY: assert property (@(posedge clock) disable iff (!reset_n)
        (go && !busy && byte_order_sel == sbr_pkg::ORDER_GAP
         && word_length == sbr_pkg::LEN_32)
        |=> q.gap_en && q.word == $past(tx_word))
        else $error("order 11 changed the word or lost gaps");
    AST_LEN_GUARD: assert property (@(posedge clock) disable iff (!reset_n)
        (go && !busy && word_length == 5'h08)
        |=> q.word[31:24] == $past(tx_word[7:0]))
        else $error("8-bit word was reordered");
    AST_IRQ_GATE: assert property (@(posedge clock) disable iff (!reset_n)
        (!irq_enable)[*2] |-> !irq)
        else $error("interrupt raised while disabled");
    // no done while busy, done after completion
    AST_DONE_BUSY: assert property (@(posedge clock) disable iff (!reset_n)
        busy |-> !transfer_done)
        else $error("done flag high during transfer");
    AST_DONE_SET: assert property (@(posedge clock) disable iff (!reset_n)
        (busy && ack_s == q.req_tgl) |=> transfer_done && !busy)
        else $error("completion did not set the done flag");
    AST_DONE_CLEAR: assert property (@(posedge clock) disable iff (!reset_n)
        (transfer_done && !busy && !go) |=> (transfer_done == !$past(done_clear)))
        else $error("done flag clear misbehaved");
    // slave never drives clock or select
    AST_ROLE: assert property (@(posedge clock) disable iff (!reset_n)
        slave_mode |-> !serial_clock_pin_oe && !ss_n_oe)
        else $error("slave drives clock or select");

    COV_TRANSFER: cover property (@(posedge clock) disable iff (!reset_n)
        go && !busy ##[1:300] transfer_done);
    COV_IRQ: cover property (@(posedge clock) disable iff (!reset_n)
        irq ##1 done_clear ##1 !irq);
    COV_SWAP_GAP: cover property (@(posedge clock) disable iff (!reset_n)
        go && !busy && byte_order_sel == sbr_pkg::ORDER_SWAP_GAP);
endmodule // sbr_ctrl

// ==== sbr_peer.sv ====
// Purpose: far-side serial peer that captures each frame for the bench
// Assumes: data is steady at the rising edge of the serial clock
// Notes:   select idles high, as with a pull-up, while not requested
module sbr_peer (
    // link
    input  wire logic        link_clk,
    input  wire logic        serial_clock_pin,
    input  wire logic        serial_data,
    input  wire logic        data_oe,
    // select towards the block in slave mode
    input  wire logic        select_req,
    output logic             ss_n,
    // captured frame
    output logic [31:0]      rx_word,
    output logic [5:0]       rx_bits,
    output logic [4:0]       max_gap,
    output int               rx_count
);
    timeunit 1ns;
    timeprecision 1ps;
    int unsigned link_cycle = 0;
    int unsigned last_edge = 0;
    initial begin
        rx_word = 32'h0;
        rx_bits = 6'h00;
        max_gap = 5'h00;
        rx_count = 0;
    end
    assign ss_n = !select_req;
    always @(posedge link_clk) begin
        link_cycle <= link_cycle + 1;
    end
    always @(posedge data_oe) begin
        rx_word = 32'h0;
        rx_bits = 6'h00;
        max_gap = 5'h00;
    end
    // gap is measured in idle link cycles between two clock pulses
    always @(posedge serial_clock_pin) begin
        if (data_oe) begin
            if (rx_bits != 6'h00 && link_cycle - last_edge - 1 > max_gap)
                max_gap = 5'(link_cycle - last_edge - 1);
            last_edge = link_cycle;
            rx_word = {rx_word[30:0], serial_data};
            rx_bits = rx_bits + 6'h01;
        end
    end
    always @(negedge data_oe) begin
        rx_count = rx_count + 1;
    end
endmodule // sbr_peer

// ==== spi_byte_reorder_mode_control_test.sv ====
// Purpose: self-checking bench for the byte order and role control block
// Assumes: link clock runs free, unrelated in phase to the system clock
// Notes:   the driver queues frame results, a watcher compares them
module spi_byte_reorder_mode_control_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock, link_clk, reset_n, fifo_mode, slave_mode, irq_enable;
    logic [1:0]  byte_order_sel, burst_count;
    logic [4:0]  word_length, max_gap;
    logic [3:0]  suspend_cycles;
    logic [31:0] tx_word, rx_word;
    logic        go, done_clear, busy, transfer_done, irq, config_error;
    logic        ss_n_i, ss_n_o, ss_n_oe, sck, sck_oe, sdo, sdo_oe, select_req;
    logic [5:0]  rx_bits;
    logic [42:0] e;
    logic [42:0] exp_q[$];
    int          rx_count, n_errors = 0, cmp_count = 0;
    sbr_ctrl sbr_ctrl_inst (.clock(clock), .reset_n(reset_n), .fifo_mode(fifo_mode),
        .byte_order_sel(byte_order_sel), .burst_count(burst_count), .slave_mode(slave_mode),
        .irq_enable(irq_enable), .word_length(word_length), .suspend_cycles(suspend_cycles),
        .go(go), .tx_word(tx_word), .done_clear(done_clear), .busy(busy),
        .transfer_done(transfer_done), .irq(irq), .config_error(config_error),
        .link_clk(link_clk), .ss_n_i(ss_n_i), .ss_n_o(ss_n_o), .ss_n_oe(ss_n_oe),
        .serial_clock_pin_o(sck), .serial_clock_pin_oe(sck_oe), .serial_out_o(sdo),
        .serial_out_oe(sdo_oe));
    sbr_peer sbr_peer_inst (.link_clk(link_clk), .serial_clock_pin(sck), .serial_data(sdo),
        .data_oe(sdo_oe), .select_req(select_req), .ss_n(ss_n_i), .rx_word(rx_word),
        .rx_bits(rx_bits), .max_gap(max_gap), .rx_count(rx_count));
    initial begin
        clock = 1'b0;
        forever #5 clock = !clock;
    end
    initial begin
        link_clk = 1'b0;
        #7;
        forever #15 link_clk = !link_clk;
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (exp !== got) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    function automatic logic [31:0] exp_word(input logic [1:0] sel, input logic [4:0] len,
                                             input logic [31:0] w);
        logic [31:0] v;
        v = (len == 5'h00) ? w : (w & ((32'h1 << len) - 32'h1));
        // swap only for 16, 24, 32
        if (sel == 2'h1 || sel == 2'h2) begin
            if (len == 5'h10) v = {16'h0, w[7:0], w[15:8]};
            else if (len == 5'h18) v = {8'h0, w[7:0], w[15:8], w[23:16]};
            else if (len == 5'h00) v = {w[7:0], w[15:8], w[23:16], w[31:24]};
        end
        return v;
    endfunction
    task automatic xfer(input logic [1:0] sel, input logic [4:0] len, input logic [3:0] sp);
        logic [31:0] w;
        int          i;
        w = $urandom();
        // gaps only with sel bit 0 and full words
        exp_q.push_back({exp_word(sel, len, w), (len == 5'h00) ? 6'h20 : {1'b0, len},
                         (sel[0] && len == 5'h00) ? {1'b0, sp} + 5'h02 : 5'h00});
        @(negedge clock);
        byte_order_sel = sel;
        word_length = len;
        suspend_cycles = sp;
        tx_word = w;
        go = 1'b1;
        @(negedge clock);
        tx_word = ~w;
        chk("busy", 1'b1, busy);
        chk("transfer_done", 1'b0, transfer_done);
        // second start while busy must be ignored
        @(negedge clock);
        go = 1'b0;
        tx_word = w;
        i = 0;
        while (transfer_done !== 1'b1 && i < 3000) begin
            @(negedge clock);
            i++;
        end
        if (i >= 3000) begin
            n_errors++;
            $display("wrong value transfer_done expected 1 seen timeout");
            summarize();
        end
        chk("irq", irq_enable, irq);
    endtask
    task automatic clear_done();
        @(negedge clock);
        done_clear = 1'b1;
        @(negedge clock);
        done_clear = 1'b0;
        chk("transfer_done", 1'b0, transfer_done);
        chk("irq", 1'b0, irq);
    endtask
    initial begin
        forever begin
            @(rx_count);
            if (exp_q.size() == 0) begin
                n_errors++;
                $display("wrong value frame expected none seen %0d", rx_count);
            end else begin
                e = exp_q.pop_front();
                chk("rx_word", e[42:11], rx_word);
                chk("rx_bits", 32'(e[10:5]), 32'(rx_bits));
                chk("gap", 32'(e[4:0]), 32'(max_gap));
            end
        end
    end
    initial begin
        static logic [4:0] lens [4] = '{5'h10, 5'h18, 5'h08, 5'h10};
        static logic [5:0] cfg [5] = '{6'h20, 6'h25, 6'h30, 6'h0A, 6'h0D};
        {reset_n, fifo_mode, slave_mode, irq_enable, go, done_clear, select_req} = 7'h00;
        {byte_order_sel, burst_count, word_length, suspend_cycles, tx_word} = 45'h0;
        void'($urandom(47));
        repeat (4) @(posedge link_clk);
        @(negedge clock);
        reset_n = 1'b1;
        chk("idle", 4'h1, {busy, transfer_done, irq, ss_n_o});
        chk("pins_oe", 3'h3, {sdo_oe, ss_n_oe, sck_oe});
        repeat (10) @(negedge clock);
        irq_enable = 1'b1;
        for (int s = 0; s < 4; s++) begin
            xfer(2'(s), 5'h00, (s == 1) ? 4'h0 : (s == 3) ? 4'hF : 4'($urandom()));
            clear_done();
        end
        $display("test order codes done");
        for (int k = 0; k < 4; k++) begin
            xfer((k == 3) ? 2'h1 : 2'h2, lens[k], 4'h3);
            clear_done();
        end
        $display("test word lengths done");
        irq_enable = 1'b0;
        xfer(2'h0, 5'h00, 4'h0);
        repeat (3) @(negedge clock);
        chk("transfer_done", 1'b1, transfer_done);
        irq_enable = 1'b1;
        repeat (2) @(negedge clock);
        chk("irq", 1'b1, irq);
        clear_done();
        $display("test irq and clear done");
        slave_mode = 1'b1;
        for (int d = 0; d < 2; d++) begin
            select_req = (d == 0);
            fork
                xfer(2'h2, 5'h00, 4'h0);
                begin
                    repeat (40) @(negedge clock);
                    chk("pins", {d == 0, d != 0, 2'h0}, {sdo_oe, ss_n_o, ss_n_oe, sck_oe});
                    select_req = 1'b1;
                end
            join
            select_req = 1'b0;
            clear_done();
        end
        slave_mode = 1'b0;
        $display("test slave role done");
        for (int c = 0; c < 5; c++) begin
            fifo_mode = 1'b0;
            {byte_order_sel, burst_count} = cfg[c][4:1];
            word_length = cfg[c][0] ? 5'h10 : 5'h00;
            // other settings first, FIFO enable last
            @(negedge clock);
            fifo_mode = cfg[c][5];
            repeat (2) @(negedge clock);
            chk("config_error", (c == 1 || c == 2 || c == 4), config_error);
        end
        $display("test config check done");
        chk("pending", 32'h0, exp_q.size());
        summarize();
    end
endmodule // spi_byte_reorder_mode_control_test
